// ==== inc/pulse_gen_pkg.sv ====
// Constants, field layouts and carrier types for the reloadable pulse generator pair
// Notes on behaviour
// R1 - Entering Low, the counter loads the Low width straight from its reload register.
// R2 - Entering High, the counter loads the High width from the internal buffer.
// R3 - Buffer captures the High reload at each High-to-Low, keeping width pairs consistent.
// R4 - A width underflow that changes the output sets the underflow flag to 1.
// R5 - Flag timing 0 sets flag at both pulse ends; 1 only at High end.
// R6 - Joined 16-bit channels set both underflow flags in the same cycle; the code sets each Low-to-High flag by its own channel's flag timing.
// R7 - Writing 0 to the underflow flag clears it; software acknowledges that way.
// R8 - Underflow interrupt enable at 1 raises the request while the flag is set.
// R9 - With polarity invert, the output idles High before start and after stop.
// R10 - Inverted: Low lasts T*(high reload+1), High lasts T*(low reload+1).
// R11 - Inverted with flag timing 1, the flag sets when the output Low pulse ends.
// R12 - Inverting the prescaler channel also inverts the clock it feeds the output side.
// R13 - Normal polarity: Low lasts T*(low reload+1), High lasts T*(high reload+1).
// R14 - Mode field 00 is standalone 8-bit, 01 is cascaded 8+8.
// R15 - Run enable 1 starts counting; 0 stops the channel.
// R16 - Clock divide 01 gives one count every four bus clocks.
// R17 - In 8+8 the output side counts on both edges of the prescaler output.
// R18 - In 8+8 the output side ignores its own clock divide field.
// R19 - Clock divide 00,01,10,11 give one count per 1,4,16,64 clocks.
// R20 - Joined 16-bit mode concatenates two 8-bit reloads into one 16-bit width.
// R21 - Writing 1 to the underflow flag leaves it unchanged.
// R22 - Stopped counter idles; after start it begins with a Low phase from low reload.
package pulse_gen_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RELOAD_W = 8;
  localparam int COUNT_W = 16;
  localparam int PRE_W = 6;
  localparam int NUM_CH = 2;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_MODE0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LOW0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_HIGH0 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_LOW1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_HIGH1 = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_RUN = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_POLARITY = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;

  // ----------------------------------------
  // Mode control field positions
  // ----------------------------------------
  localparam int BIT_FLAG = 0;
  localparam int BIT_IRQ_EN = 1;
  localparam int BIT_TIMING = 2;
  localparam int BIT_DIV_LO = 3;
  localparam int BIT_MODE_LO = 5;

  // ----------------------------------------
  // Field encodings and reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_SINGLE8 = 2'h0;
  localparam logic [1:0] MODE_CASCADE = 2'h1;
  localparam logic [1:0] MODE_JOIN16 = 2'h2;
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_4 = 2'h1;
  localparam logic [1:0] DIV_16 = 2'h2;
  localparam logic [PRE_W-1:0] LAST_DIV_1 = 6'h00;
  localparam logic [PRE_W-1:0] LAST_DIV_4 = 6'h03;
  localparam logic [PRE_W-1:0] LAST_DIV_16 = 6'h0F;
  localparam logic [PRE_W-1:0] LAST_DIV_64 = 6'h3F;
  localparam logic [RELOAD_W-1:0] RELOAD_RST = 8'h00;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic underflow_flag;
    logic underflow_irq_enable;
    logic flag_timing_select;
    logic [1:0] clock_divide_select;
    logic [1:0] operation_mode_select;
    logic [RELOAD_W-1:0] low_width_reload;
    logic [RELOAD_W-1:0] high_width_reload;
    logic run_enable_bit;
    logic polarity_invert;
    logic active;
    logic level;
    logic edge_seen;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] high_buffer;
    logic [PRE_W-1:0] pre;
  } chan_type;

  typedef struct packed {
    chan_type [NUM_CH-1:0] ch;
    logic [DATA_W-1:0] rdata;
  } state_type;

endpackage

// ==== hw/pulse_gen_pair.sv ====
// Pair of reloadable pulse generator channels with register port
`timescale 1ns/1ns
`default_nettype none
module pulse_gen_pair (
  input wire logic mclk,
  input wire logic rst,
  input wire pulse_gen_pkg::reg_req_type req,
  output logic [pulse_gen_pkg::DATA_W-1:0] reg_rdata,
  output logic [pulse_gen_pkg::NUM_CH-1:0] pulse_out,
  output logic [pulse_gen_pkg::NUM_CH-1:0] irq
);
  import pulse_gen_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_type s_q;
  state_type s_d;
  logic joined;
  logic cascade;
  logic [NUM_CH-1:0] go;
  logic [NUM_CH-1:0] tick_own;
  logic [NUM_CH-1:0] tick;
  logic [1:0] div_sel [NUM_CH];
  logic [PRE_W-1:0] div_last [NUM_CH];
  logic [COUNT_W-1:0] low_w [NUM_CH];
  logic [COUNT_W-1:0] high_w [NUM_CH];

  function automatic logic [DATA_W-1:0] mode_word(input chan_type c);
    logic [DATA_W-1:0] w;
    w = '0;
    w[BIT_FLAG] = c.underflow_flag;
    w[BIT_IRQ_EN] = c.underflow_irq_enable;
    w[BIT_TIMING] = c.flag_timing_select;
    w[BIT_DIV_LO +: 2] = c.clock_divide_select;
    w[BIT_MODE_LO +: 2] = c.operation_mode_select;
    return w;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    joined = (s_q.ch[0].operation_mode_select == MODE_JOIN16);
    cascade = (s_q.ch[0].operation_mode_select == MODE_CASCADE); // see R14
    // Register writes
    if (req.wr) begin
      unique case (req.addr)
        OFF_MODE0, OFF_MODE1: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (req.addr == (i == 0 ? OFF_MODE0 : OFF_MODE1)) begin
              // Only a written 0 clears; a 1 leaves the flag alone
              if (!req.wdata[BIT_FLAG]) begin
                s_d.ch[i].underflow_flag = 1'b0; // see R7, R21
              end
              s_d.ch[i].underflow_irq_enable = req.wdata[BIT_IRQ_EN];
              s_d.ch[i].flag_timing_select = req.wdata[BIT_TIMING];
              s_d.ch[i].clock_divide_select = req.wdata[BIT_DIV_LO +: 2];
              s_d.ch[i].operation_mode_select = req.wdata[BIT_MODE_LO +: 2];
            end
          end
        end
        OFF_LOW0: s_d.ch[0].low_width_reload = req.wdata[RELOAD_W-1:0];
        OFF_HIGH0: s_d.ch[0].high_width_reload = req.wdata[RELOAD_W-1:0];
        OFF_LOW1: s_d.ch[1].low_width_reload = req.wdata[RELOAD_W-1:0];
        OFF_HIGH1: s_d.ch[1].high_width_reload = req.wdata[RELOAD_W-1:0];
        OFF_RUN: begin
          s_d.ch[0].run_enable_bit = req.wdata[0]; // see R15
          s_d.ch[1].run_enable_bit = req.wdata[1]; // see R15
        end
        OFF_POLARITY: begin
          s_d.ch[0].polarity_invert = req.wdata[0];
          s_d.ch[1].polarity_invert = req.wdata[1];
        end
        default: ;
      endcase
    end
    // Channel engines
    for (int i = 0; i < NUM_CH; i++) begin
      // Joined pair runs as one counter on the even channel's run and divide settings
      go[i] = joined ? s_q.ch[0].run_enable_bit : s_q.ch[i].run_enable_bit;
      div_sel[i] = joined ? s_q.ch[0].clock_divide_select : s_q.ch[i].clock_divide_select;
      unique case (div_sel[i]) // see R16, R19
        DIV_1: div_last[i] = LAST_DIV_1;
        DIV_4: div_last[i] = LAST_DIV_4;
        DIV_16: div_last[i] = LAST_DIV_16;
        default: div_last[i] = LAST_DIV_64;
      endcase
      tick_own[i] = (s_q.ch[i].pre == div_last[i]);
      // Both edges of the prescaler output clock the output side; inversion
      // moves no edge, so the inverted feed keeps the same count rate
      tick[i] = (i == 0 && cascade) ? s_q.ch[1].edge_seen : tick_own[i]; // see R12, R17, R18
      if (joined) begin
        low_w[i] = {s_q.ch[1].high_width_reload, s_q.ch[1].low_width_reload}; // see R20
        high_w[i] = {s_q.ch[0].high_width_reload, s_q.ch[0].low_width_reload}; // see R20
      end else begin
        low_w[i] = {8'h00, s_q.ch[i].low_width_reload};
        high_w[i] = {8'h00, s_q.ch[i].high_width_reload};
      end
      s_d.ch[i].edge_seen = 1'b0;
      if (!go[i]) begin
        s_d.ch[i].active = 1'b0; // see R22
        s_d.ch[i].level = 1'b0;
        s_d.ch[i].pre = '0;
      end else if (!s_q.ch[i].active) begin
        s_d.ch[i].active = 1'b1;
        s_d.ch[i].level = 1'b0;
        s_d.ch[i].count = low_w[i]; // see R22
        s_d.ch[i].high_buffer = high_w[i]; // see R3
        s_d.ch[i].pre = '0;
      end else begin
        s_d.ch[i].pre = tick_own[i] ? '0 : s_q.ch[i].pre + 6'h01;
        if (tick[i]) begin
          if (s_q.ch[i].count == '0) begin
            // N+1 ticks per phase: load N, count down to 0, then switch
            s_d.ch[i].edge_seen = 1'b1;
            s_d.ch[i].level = ~s_q.ch[i].level;
            if (s_q.ch[i].level) begin
              s_d.ch[i].count = low_w[i]; // see R1, R13
              s_d.ch[i].high_buffer = high_w[i]; // see R3
              s_d.ch[i].underflow_flag = 1'b1; // see R4, R5, R6, R11
            end else begin
              s_d.ch[i].count = s_q.ch[i].high_buffer; // see R2, R13
              if (!s_q.ch[i].flag_timing_select) begin
                s_d.ch[i].underflow_flag = 1'b1; // see R4, R5
              end
            end
          end else begin
            s_d.ch[i].count = s_q.ch[i].count - 16'h0001;
          end
        end
      end
    end
    // Read data, one cycle later
    if (req.rd) begin
      unique case (req.addr)
        OFF_MODE0: s_d.rdata = mode_word(s_q.ch[0]);
        OFF_MODE1: s_d.rdata = mode_word(s_q.ch[1]);
        OFF_LOW0: s_d.rdata = {24'h00_0000, s_q.ch[0].low_width_reload};
        OFF_HIGH0: s_d.rdata = {24'h00_0000, s_q.ch[0].high_width_reload};
        OFF_LOW1: s_d.rdata = {24'h00_0000, s_q.ch[1].low_width_reload};
        OFF_HIGH1: s_d.rdata = {24'h00_0000, s_q.ch[1].high_width_reload};
        OFF_RUN: s_d.rdata = {30'h0000_0000, s_q.ch[1].run_enable_bit, s_q.ch[0].run_enable_bit};
        OFF_POLARITY: s_d.rdata = {30'h0000_0000, s_q.ch[1].polarity_invert, s_q.ch[0].polarity_invert};
        OFF_STATUS: s_d.rdata = {28'h000_0000, pulse_out, s_q.ch[1].active, s_q.ch[0].active};
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = s_q.rdata;
  for (genvar g = 0; g < NUM_CH; g++) begin : g_out
    // Idle level is raw Low, so inversion idles the pin High
    assign pulse_out[g] = s_q.ch[g].level ^ s_q.ch[g].polarity_invert; // see R9, R10
    assign irq[g] = s_q.ch[g].underflow_flag & s_q.ch[g].underflow_irq_enable; // see R8
  end

endmodule
`default_nettype wire

// ==== dv/pulse_gen_properties.sv ====
// Port-level properties of the pulse generator pair
`timescale 1ns/1ns
`default_nettype none
module pulse_gen_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire pulse_gen_pkg::reg_req_type req,
  input wire logic [pulse_gen_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [pulse_gen_pkg::NUM_CH-1:0] pulse_out,
  input wire logic [pulse_gen_pkg::NUM_CH-1:0] irq
);
  import pulse_gen_pkg::*;
  // ----------------------------------------
  // Register shadows
  // ----------------------------------------
  logic [1:0] run_q, pol_q, en_q, tim_q;
  logic join_q;
  logic [2:0] idle_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {run_q, pol_q, en_q, tim_q, join_q} <= 9'h000;
      idle_q <= 3'h0;
    end else begin
      if (req.wr && req.addr == OFF_RUN) run_q <= req.wdata[1:0];
      if (req.wr && req.addr == OFF_POLARITY) pol_q <= req.wdata[1:0];
      if (req.wr && req.addr == OFF_MODE0) {join_q, tim_q[0], en_q[0]} <=
        {req.wdata[6:5] == MODE_JOIN16, req.wdata[BIT_TIMING], req.wdata[BIT_IRQ_EN]};
      if (req.wr && req.addr == OFF_MODE1) {tim_q[1], en_q[1]} <= {req.wdata[BIT_TIMING], req.wdata[BIT_IRQ_EN]};
      // Saturates so a long stop never wraps back
      idle_q <= run_q[0] ? 3'h0 : (idle_q == 3'h7 ? idle_q : idle_q + 3'h1);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(req.rd) |-> reg_rdata == 32'h0000_0000) else $error("read data outside read slot");
  a_rdata_upper: assert property (reg_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  a_unmapped_zero: assert property (req.rd && req.addr > OFF_STATUS |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_idle_level: assert property (idle_q >= 3'h3 |-> pulse_out[0] == pol_q[0]) else $error("idle level wrong");
  a_irq_mask: assert property (!en_q[0] |-> !irq[0]) else $error("masked request raised");
  a_flag_edge: assert property ($rose(irq[0]) && $past(en_q[0]) |-> ##[0:1] $changed(pulse_out[0]))
    else $error("flag without output change");
  a_flag_timing: assert property ($rose(irq[0]) && $past(en_q[0] && tim_q[0]) |->
    ##[0:1] ($changed(pulse_out[0]) && pulse_out[0] == pol_q[0])) else $error("flag at wrong pulse end");
  a_join_flags: assert property (($rose(irq[0]) || $rose(irq[1])) && join_q && $past(en_q) == 2'h3 |-> irq == 2'h3)
    else $error("joined flags apart");
  c_flag: cover property ($rose(irq[0]) && tim_q[0]);
  c_join: cover property (join_q && $rose(irq[1]));
  c_idle_inv: cover property (idle_q == 3'h3 && pol_q[0]);
endmodule
bind pulse_gen_pair pulse_gen_properties pulse_gen_properties_i (.mclk(mclk), .rst(rst), .req(req),
  .reg_rdata(reg_rdata), .pulse_out(pulse_out), .irq(irq));
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the pulse generator pair
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pulse_gen_pkg::*;
  logic mclk;
  logic rst;
  reg_req_type req;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_CH-1:0] pulse_out, irq;
  int fail_count, checks, n, dv;
  logic [7:0] lo, hi;
  logic [31:0] cfg;
  logic [7:0] regs [4] = '{OFF_LOW0, OFF_HIGH0, OFF_LOW1, OFF_HIGH1};
  pulse_gen_pair pulse_gen_pair_i (.mclk(mclk), .rst(rst), .req(req), .reg_rdata(reg_rdata),
    .pulse_out(pulse_out), .irq(irq));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_w(input int got, input int exp);
    checks++;
    if (got != exp) begin
      fail_count++;
      $display("BAD t=%0t width=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected phase length: reload plus one, times the count period
  function automatic int exp_width(input logic [7:0] reload, input int period);
    return (int'(reload) + 1) * period;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask
  // Waits for the level, then counts whole cycles spent at it
  task automatic width(input int ch, input logic lvl, output int w);
    int g;
    g = 0;
    w = 0;
    while (pulse_out[ch] !== lvl && g < 4000) begin
      @(posedge mclk);
      #1 g++;
    end
    while (pulse_out[ch] === lvl && g < 4000) begin
      @(posedge mclk);
      #1 g++;
      w++;
    end
    if (g >= 4000) begin
      fail_count++;
      stop_test();
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h2c22c046));
    req = '0;
    rst = 1'b1;
    fail_count = 0;
    checks = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(OFF_RUN, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      cfg = $urandom;
      wr(regs[i], cfg);
      rd(regs[i], cfg & 32'h0000_00ff);
    end
    rd(8'h40, 32'h0000_0000);
    for (int d = 0; d < 4; d++) begin
      lo = 8'($urandom_range(3));
      hi = 8'($urandom_range(3));
      dv = 1 << (2 * d);
      wr(OFF_POLARITY, 32'(d % 2));
      wr(OFF_LOW0, 32'(lo));
      wr(OFF_HIGH0, 32'(hi));
      wr(OFF_MODE0, 32'(d) << BIT_DIV_LO);
      wr(OFF_RUN, 32'h0000_0001);
      width(0, 1'(1 - d % 2), n);
      cmp_w(n, exp_width(hi, dv));
      width(0, 1'(d % 2), n);
      cmp_w(n, exp_width(lo, dv));
      wr(OFF_RUN, 32'h0000_0000);
    end
    wr(OFF_LOW0, 32'h0000_0000);
    wr(OFF_HIGH0, 32'h0000_0000);
    for (int t = 0; t < 2; t++) begin
      cfg = 32'(t) << BIT_TIMING | 32'h0000_0002;
      wr(OFF_POLARITY, 32'(t));
      wr(OFF_MODE0, cfg);
      wr(OFF_RUN, 32'h0000_0001);
      width(0, 1'b1, n);
      width(0, 1'b0, n);
      wr(OFF_RUN, 32'h0000_0000);
      rd(OFF_MODE0, cfg | 32'h0000_0001);
      cmp(32'(irq[0]), 32'h0000_0001);
      wr(OFF_MODE0, cfg | 32'h0000_0001);
      rd(OFF_MODE0, cfg | 32'h0000_0001);
      wr(OFF_MODE0, cfg);
      rd(OFF_MODE0, cfg);
    end
    // Timing 1: the end of the first Low pulse must not raise the flag
    wr(OFF_POLARITY, 32'h0000_0000);
    wr(OFF_HIGH0, 32'h0000_0010);
    wr(OFF_MODE0, 32'h0000_0006);
    wr(OFF_RUN, 32'h0000_0001);
    width(0, 1'b0, n);
    rd(OFF_MODE0, 32'h0000_0006);
    cmp(32'(irq[0]), 32'h0000_0000);
    wr(OFF_RUN, 32'h0000_0000);
    wr(OFF_POLARITY, 32'h0000_0000);
    wr(OFF_MODE0, 32'h0000_0000);
    wr(OFF_LOW0, 32'h0000_0005);
    wr(OFF_HIGH0, 32'h0000_0005);
    wr(OFF_RUN, 32'h0000_0001);
    wr(OFF_LOW0, 32'h0000_0002);
    wr(OFF_HIGH0, 32'h0000_0009);
    width(0, 1'b1, n);
    cmp_w(n, 6);
    width(0, 1'b0, n);
    cmp_w(n, 3);
    width(0, 1'b1, n);
    cmp_w(n, 10);
    wr(OFF_RUN, 32'h0000_0000);
    // Prescaler side inverted: edge count must stay the same
    wr(OFF_POLARITY, 32'h0000_0002);
    wr(OFF_MODE1, 32'h0000_0000);
    wr(OFF_LOW1, 32'h0000_0001);
    wr(OFF_HIGH1, 32'h0000_0001);
    wr(OFF_HIGH0, 32'h0000_0002);
    wr(OFF_LOW0, 32'h0000_0000);
    wr(OFF_MODE0, 32'(MODE_CASCADE) << BIT_MODE_LO | 32'h0000_0018);
    wr(OFF_RUN, 32'h0000_0003);
    width(0, 1'b1, n);
    cmp_w(n, 6);
    width(0, 1'b0, n);
    cmp_w(n, 2);
    wr(OFF_RUN, 32'h0000_0000);
    wr(OFF_POLARITY, 32'h0000_0000);
    wr(OFF_HIGH1, 32'h0000_0001);
    wr(OFF_LOW1, 32'h0000_0000);
    wr(OFF_HIGH0, 32'h0000_0000);
    wr(OFF_LOW0, 32'h0000_0002);
    wr(OFF_MODE1, 32'h0000_0002);
    wr(OFF_MODE0, 32'(MODE_JOIN16) << BIT_MODE_LO | 32'h0000_0002);
    wr(OFF_RUN, 32'h0000_0001);
    width(0, 1'b1, n);
    cmp_w(n, 3);
    width(0, 1'b0, n);
    cmp_w(n, 257);
    cmp(32'(pulse_out[1]), 32'(pulse_out[0]));
    cmp(32'(irq), 32'h0000_0003);
    stop_test();
  end
endmodule
`default_nettype wire
